// ### hw/pbfs_apb_slave.v
// apb slave front end: decodes a transfer into one-cycle strobes
`timescale 1ns/1ps
module pbfs_apb_slave (
    input wire clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg pready,
    output reg [11:0] req_addr,
    output reg [31:0] req_wdata,
    output reg [3:0] req_strb,
    output reg req_wr,
    output reg req_rd
);
    // one wait state: ready follows the first access cycle
    always @(posedge clk) begin
        if (reset) begin
            pready <= 1'b0;
        end else begin
            pready <= psel & penable & ~pready;
        end
    end

    // strobes decoded in the first access cycle itself, so that the write
    // lands and the read data is registered at the edge that raises ready
    always @* begin
        req_wr = psel & penable & ~pready & pwrite;
        req_rd = psel & penable & ~pready & ~pwrite;
        req_addr = paddr;
        req_wdata = pwdata;
        req_strb = pstrb;
    end
endmodule // pbfs_apb_slave

// ### hw/pbfs_defs.vh
// register offsets, field positions and reset values for the port b mux
`ifndef PBFS_DEFS_VH
`define PBFS_DEFS_VH
`define PBFS_OFS_DIR 12'h000
`define PBFS_OFS_FUN_UP 12'h004
`define PBFS_OFS_FUN_LO 12'h008
`define PBFS_OFS_PIN_IN 12'h00C
`define PBFS_DIR_MASK 16'h3FFF
`define PBFS_FUN_UP_MASK 16'h0555
`define PBFS_FUN_LO_MASK 16'h5555
`define PBFS_DIR_RST 16'h0000
`define PBFS_FUN_RST 16'h0000
`define PBFS_PIN_COUNT 14
`endif

// ### hw/pbfs_port_b_mux.v
// port b pin function and direction select with apb registers
//
// Added by the designer: the register offsets and register access over APB.
`include "pbfs_defs.vh"
`timescale 1ns/1ps
module pbfs_port_b_mux #(
    parameter PINS = `PBFS_PIN_COUNT
) (
    input wire clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0] pstrb,
    output reg [31:0] prdata,
    output wire pready,
    output reg pslverr,
    input wire [PINS-1:0] gpio_out,
    output reg [PINS-1:0] gpio_in,
    input wire bus_strobe_out,
    input wire chip_select_3,
    input wire chip_select_4,
    input wire chip_select_5b,
    input wire card_enable_2a,
    input wire chip_select_6b,
    input wire card_enable_2b,
    input wire card_io_write_strobe,
    input wire card_io_read_strobe,
    input wire row_address_strobe,
    input wire column_address_strobe,
    input wire memory_clock_enable,
    output reg io_sixteen_bit_indicator,
    output reg wait_request,
    input wire [PINS-1:0] pin_in,
    output reg [PINS-1:0] pin_out,
    output reg [PINS-1:0] pin_oe
);
    reg [15:0] port_b_direction;
    reg [15:0] port_b_function_upper;
    reg [15:0] port_b_function_lower;
    wire [11:0] req_addr;
    wire [31:0] req_wdata;
    wire [3:0] req_strb;
    wire req_wr;
    wire req_rd;
    wire [PINS-1:0] pin_sync;
    wire [PINS-1:0] fun_sel;
    wire [PINS-1:0] ctl_out;
    wire [PINS-1:0] ctl_is_in;
    wire [PINS-1:0] next_pin_out;
    wire [PINS-1:0] next_pin_oe;
    reg [31:0] next_prdata;
    reg next_pslverr;

    // byte-lane merge of a write into a 16-bit register
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] wd;
        input [3:0] st;
        input [15:0] mask;
        reg [15:0] tmp;
        begin
            tmp = old;
            if (st[0])
                tmp[7:0] = wd[7:0];
            if (st[1])
                tmp[15:8] = wd[15:8];
            merge16 = tmp & mask;
        end
    endfunction

    pbfs_apb_slave u_apb (
        .clk(clk),
        .reset(reset),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .pready(pready),
        .req_addr(req_addr),
        .req_wdata(req_wdata),
        .req_strb(req_strb),
        .req_wr(req_wr),
        .req_rd(req_rd)
    );

    // pins come from outside the clock domain
    pbfs_sync #(
        .WIDTH(PINS)
    ) u_sync (
        .clk(clk),
        .reset(reset),
        .async_in(pin_in),
        .sync_out(pin_sync)
    );

    // register writes; masks keep reserved bits at zero
    always @(posedge clk) begin
        if (reset) begin
            port_b_direction <= `PBFS_DIR_RST;
            port_b_function_upper <= `PBFS_FUN_RST;
            port_b_function_lower <= `PBFS_FUN_RST;
        end else if (req_wr) begin
            case (req_addr)
                `PBFS_OFS_DIR: begin
                    port_b_direction <= merge16(port_b_direction,
                        req_wdata, req_strb, `PBFS_DIR_MASK);
                end
                `PBFS_OFS_FUN_UP: begin
                    port_b_function_upper <= merge16(port_b_function_upper,
                        req_wdata, req_strb, `PBFS_FUN_UP_MASK);
                end
                `PBFS_OFS_FUN_LO: begin
                    port_b_function_lower <= merge16(port_b_function_lower,
                        req_wdata, req_strb, `PBFS_FUN_LO_MASK);
                end
                default: begin
                    port_b_direction <= port_b_direction;
                end
            endcase
        end
    end

    // read mux; unmapped addresses answer with an error and zero data
    always @* begin
        next_prdata = 32'h00000000;
        next_pslverr = 1'b0;
        case (req_addr)
            `PBFS_OFS_DIR: next_prdata = {16'h0000, port_b_direction};
            `PBFS_OFS_FUN_UP: next_prdata = {16'h0000, port_b_function_upper};
            `PBFS_OFS_FUN_LO: next_prdata = {16'h0000, port_b_function_lower};
            `PBFS_OFS_PIN_IN: next_prdata = {18'h00000, gpio_in};
            default: next_pslverr = 1'b1;
        endcase
    end

    // read data registered in the cycle pready rises
    always @(posedge clk) begin
        if (reset) begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (req_rd | req_wr) begin
            prdata <= req_rd ? next_prdata : 32'h00000000;
            pslverr <= next_pslverr;
        end else begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
    end

    // per-pin mode bits; each pin's field sits on an even position
    assign fun_sel[13] = port_b_function_upper[10];
    assign fun_sel[12] = port_b_function_upper[8];
    assign fun_sel[11] = port_b_function_upper[6];
    assign fun_sel[10] = port_b_function_upper[4];
    assign fun_sel[9] = port_b_function_upper[2];
    assign fun_sel[8] = port_b_function_upper[0];
    assign fun_sel[7] = port_b_function_lower[14];
    assign fun_sel[6] = port_b_function_lower[12];
    assign fun_sel[5] = port_b_function_lower[10];
    assign fun_sel[4] = port_b_function_lower[8];
    assign fun_sel[3] = port_b_function_lower[6];
    assign fun_sel[2] = port_b_function_lower[4];
    assign fun_sel[1] = port_b_function_lower[2];
    assign fun_sel[0] = port_b_function_lower[0];

    // controller signal per pin; card enables have pins of their own, pins 1 and 0 drive zero
    assign ctl_out = {bus_strobe_out, chip_select_3, chip_select_4,
        chip_select_5b, card_enable_2a, chip_select_6b, card_enable_2b,
        card_io_write_strobe, card_io_read_strobe, row_address_strobe,
        column_address_strobe, memory_clock_enable, 2'b00};
    // pins 1 and 0 are controller inputs in their alternate mode
    assign ctl_is_in = 14'h0003;

    // alternate mode overrides direction; inputs release the driver
    assign next_pin_oe = (~fun_sel & port_b_direction[PINS-1:0]) |
        (fun_sel & ~ctl_is_in);
    assign next_pin_out = (~fun_sel & gpio_out) | (fun_sel & ctl_out);

    // registered pad drive: one cycle of latency, glitch-free outputs
    always @(posedge clk) begin
        if (reset) begin
            pin_oe <= {PINS{1'b0}};
            pin_out <= {PINS{1'b0}};
            gpio_in <= {PINS{1'b0}};
            io_sixteen_bit_indicator <= 1'b0;
            wait_request <= 1'b0;
        end else begin
            pin_oe <= next_pin_oe;
            pin_out <= next_pin_out;
            gpio_in <= pin_sync;
            // controller inputs idle low when the pin is general i/o
            io_sixteen_bit_indicator <= fun_sel[1] & pin_sync[1];
            wait_request <= fun_sel[0] & pin_sync[0];
        end
    end
endmodule // pbfs_port_b_mux

// ### hw/pbfs_sync.v
// two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module pbfs_sync #(
    parameter WIDTH = 14
) (
    input wire clk,
    input wire reset,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1;

    // first stage feeds only the second
    always @(posedge clk) begin
        if (reset) begin
            stage1 <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // pbfs_sync

// ### sim/pbfs_far_side.sv
// far side model: bus controller levels and outside pin drivers
`timescale 1ns/1ps
module pbfs_far_side (
    input logic clk,
    input logic hold,
    input logic [13:0] level,
    input logic [13:0] pin_out,
    input logic [13:0] pin_oe,
    output logic [11:0] bus_state_controller,
    output logic [13:0] pin_in
);
    logic [13:0] ext;
    // strobes wander freely; outside drive is noise unless held
    always @(posedge clk) begin
        bus_state_controller <= 12'($urandom);
        ext <= hold ? level : 14'($urandom);
    end
    // our driver wins where enabled, else the outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule // pbfs_far_side

// ### sim/pbfs_port_b_mux_tb.sv
// self-checking bench for the port b function select block
`timescale 1ns/1ps
module pbfs_port_b_mux_tb;
    logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
    logic hold = 0, pready, pslverr, er, io16, waitr;
    logic [11:0] paddr = 12'h000, a, bus_state_controller;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [31:0] mask [3] = '{32'h3FFF, 32'h0555, 32'h5555};
    logic [13:0] gpio_out = 14'h0, gpio_in, pin_in, pin_out, pin_oe;
    logic [13:0] level = 14'h0, eoe, eout, xo, xd;
    logic [15:0] m_dir = 0, m_up = 0, m_lo = 0;
    wire [27:0] sel = {m_up[11:0], m_lo};
    wire [13:0] bpin = {bus_state_controller, 2'h0};
    wire [13:0] po = pin_out & xo;
    wire [13:0] eo = xd & xo;
    int bad_count = 0, checks_done = 0;
    pbfs_port_b_mux u_pbfs_port_b_mux (.clk, .reset, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr,
        .gpio_out, .gpio_in, .bus_strobe_out(bus_state_controller[11]),
        .chip_select_3(bus_state_controller[10]), .chip_select_4(bus_state_controller[9]),
        .chip_select_5b(bus_state_controller[8]), .card_enable_2a(bus_state_controller[7]),
        .chip_select_6b(bus_state_controller[6]), .card_enable_2b(bus_state_controller[5]),
        .card_io_write_strobe(bus_state_controller[4]), .card_io_read_strobe(bus_state_controller[3]),
        .row_address_strobe(bus_state_controller[2]), .column_address_strobe(bus_state_controller[1]),
        .memory_clock_enable(bus_state_controller[0]), .io_sixteen_bit_indicator(io16),
        .wait_request(waitr), .pin_in, .pin_out, .pin_oe);
    pbfs_far_side u_pbfs_far_side (.clk, .hold, .level, .pin_out, .pin_oe,
        .bus_state_controller, .pin_in);
    initial forever #2.5 clk = ~clk;
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_pin(input logic [13:0] got, input logic [13:0] exp);
        chk_val({18'h0, got}, {18'h0, exp});
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // one apb transfer; idle edge first so psel never toggles in one step
    task automatic apb(input logic w, input logic [11:0] ad,
                       input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 40);
        if (n == 40) bad_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // register model takes a write at the edge the slave takes it
    always @(posedge clk) begin
        gpio_out <= 14'($urandom);
        if (reset) {m_dir, m_up, m_lo} <= 48'h0;
        else if (psel && penable && !pready && pwrite) begin
            if (paddr == 12'h000) m_dir <= pwdata[15:0] & 16'h3FFF;
            if (paddr == 12'h004) m_up <= pwdata[15:0] & 16'h0555;
            if (paddr == 12'h008) m_lo <= pwdata[15:0] & 16'h5555;
        end
    end
    // expected pin drive, from model registers and live inputs
    always_comb begin
        for (int i = 0; i < 14; i++) begin
            eoe[i] = sel[2*i] ? i > 1 : m_dir[i];
            eout[i] = sel[2*i] ? bpin[i] : gpio_out[i];
        end
    end
    // pins are registered once, so compare against last cycle's view
    always @(posedge clk) begin
        if (!reset) begin
            chk_pin(pin_oe, xo);
            chk_pin(po & 14'h3F00, eo & 14'h3F00);
            chk_pin(po & 14'h00FF, eo & 14'h00FF);
        end
        xo <= eoe;
        xd <= eout;
    end
    initial begin
        void'($urandom(32'hB270));
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        // reset values, then all ones to see reserved bits stay clear
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            chk_val(rd, 32'h0);
            apb(1'b1, 12'(4 * i), 32'hFFFFFFFF);
            apb(1'b0, 12'(4 * i), 32'h0);
            chk_val(rd, mask[i]);
        end
        apb(1'b1, 12'h010, 32'hFFFF);
        chk_val({31'h0, er}, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        chk_val(rd, 32'h0);
        // every mode field set in turn, the other function register keeping its last value, random directions underneath
        for (int i = 0; i < 14; i++) begin
            apb(1'b1, 12'h000, $urandom);
            apb(1'b1, i < 8 ? 12'h008 : 12'h004, 32'h1 << (2 * i % 16));
            repeat (4) @(posedge clk);
        end
        // random register traffic with read-back against the model
        repeat (20) begin
            a = 12'(4 * ($urandom % 3));
            apb(1'b1, a, $urandom);
            apb(1'b0, a, 32'h0);
            chk_val(rd, {16'h0, a == 0 ? m_dir : a == 4 ? m_up : m_lo});
        end
        // pins 1 and 0 feed the controller only in alternate mode
        apb(1'b1, 12'h008, 32'h5);
        hold <= 1'b1;
        for (int v = 0; v < 4; v++) begin
            level <= 14'(v);
            repeat (8) @(posedge clk);
            chk_val({30'h0, io16, waitr}, 32'(v));
        end
        apb(1'b1, 12'h008, 32'h0);
        repeat (8) @(posedge clk);
        chk_val({30'h0, io16, waitr}, 32'h0);
        // all pins inputs: outside level reaches the status word
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b1, 12'h004, 32'h0);
        level <= 14'h2A5A;
        repeat (8) @(posedge clk);
        chk_pin(gpio_in, 14'h2A5A);
        apb(1'b0, 12'h00C, 32'h0);
        chk_val(rd, 32'h2A5A);
        stop_test();
    end
    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #50000;
        bad_count++;
        stop_test();
    end
endmodule // pbfs_port_b_mux_tb

// ### sim/pbfs_props.sv
// port-level assertions for the port b function select block
`timescale 1ns/1ps
module pbfs_props (
    input wire clk,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [13:0] gpio_in,
    input wire [13:0] pin_in,
    input wire [13:0] pin_out,
    input wire [13:0] pin_oe,
    input wire wait_request
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic [2:0] age;
    // edges since reset, so the input pipe is not judged while it refills
    always @(posedge clk)
        age <= reset ? 3'h0 : age + {2'h0, age != 3'h7};
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    ready_next_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer the cycle after access");
    data_idle_a: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside the answer cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    err_unmapped_a: assert property
        (psel && penable && !pready && paddr > 12'h00C |=> pslverr)
        else $error("unmapped address not flagged");
    reset_pins_a: assert property (disable iff (1'b0)
        reset |=> pin_oe == 14'h0 && pin_out == 14'h0)
        else $error("pins not cleared by reset");
    oe_hold_a: assert property (!psel [*3] |-> $stable(pin_oe))
        else $error("driver enable moved without a write");
    input_delay_a: assert property
        (age > 3'h3 |-> gpio_in == $past(pin_in, 3))
        else $error("pin level not seen three cycles later");
    cover property (pready && !pslverr);
    cover property (pslverr);
    cover property (wait_request);
endmodule // pbfs_props
bind pbfs_port_b_mux pbfs_props u_pbfs_props (.clk, .reset, .psel,
    .penable, .paddr, .prdata, .pready, .pslverr, .gpio_in, .pin_in,
    .pin_out, .pin_oe, .wait_request);
